// ==== bfo_regs.svh ====
// Constants for the bit-oriented file-register instruction decoder.
`ifndef BFO_REGS_SVH
`define BFO_REGS_SVH

// ==========================================================================
// Instruction word fields
// ==========================================================================
`define BFO_WORD_W       14
`define BFO_ADDR_LSB     0
`define BFO_ADDR_MSB     6
`define BFO_BIT_LSB      7
`define BFO_BIT_MSB      9
`define BFO_OP_LSB       10
`define BFO_OP_MSB       13
`define BFO_OP_CLEAR     4'h4
`define BFO_OP_SET       4'h5
`define BFO_OP_TEST_CLR  4'h6

// ==========================================================================
// Reset values
// ==========================================================================
`define BFO_RST_ADDR     7'h00
`define BFO_RST_DATA     8'h00

`endif

// ==== bfo_pkg.sv ====
// Types for the bit-oriented file-register instruction decoder.
package bfo_pkg;
    typedef logic [13:0] bfo_word_t;
    typedef logic [6:0]  bfo_addr_t;
    typedef logic [2:0]  bfo_bit_t;
    typedef logic [7:0]  bfo_data_t;
    typedef enum logic [1:0] {
        BFO_OP_NONE  = 2'b00,
        BFO_OP_CLR   = 2'b01,
        BFO_OP_SET   = 2'b10,
        BFO_OP_TST   = 2'b11
    } bfo_op_t;
    typedef enum logic [0:0] {
        BFO_ST_RUN   = 1'b0,
        BFO_ST_FLUSH = 1'b1
    } bfo_state_t;
endpackage

// ==== bfo_decode.sv ====
// Field decoder for one instruction word.
`timescale 1ns/1ps
`include "bfo_regs.svh"

module bfo_decode (
    // Instruction word
    input  wire logic [13:0] word_i,
    // Decoded fields
    output logic      [1:0]  op_o,
    output logic      [6:0]  addr_o,
    output logic      [2:0]  bit_o
);
    import bfo_pkg::*;

    // ======================================================================
    // Field extraction
    // ======================================================================
    always_comb begin
        addr_o = word_i[`BFO_ADDR_MSB:`BFO_ADDR_LSB];
        bit_o  = word_i[`BFO_BIT_MSB:`BFO_BIT_LSB];
        if (word_i[`BFO_OP_MSB:`BFO_OP_LSB] == `BFO_OP_CLEAR) begin
            op_o = BFO_OP_CLR;
        end else if (word_i[`BFO_OP_MSB:`BFO_OP_LSB] == `BFO_OP_SET) begin
            op_o = BFO_OP_SET;
        end else if (word_i[`BFO_OP_MSB:`BFO_OP_LSB] == `BFO_OP_TEST_CLR) begin
            op_o = BFO_OP_TST;
        end else begin
            op_o = BFO_OP_NONE;
        end
    end
endmodule

// ==== bfo_exec.sv ====
// Execute stage for bit clear, bit set and bit test with skip.
`timescale 1ns/1ps
`include "bfo_regs.svh"

module bfo_exec (
    // Clock and reset
    input  wire logic            core_clk_i,
    input  wire logic            reset_i,
    // Instruction from the fetch pipeline
    input  wire bfo_pkg::bfo_word_t instr_i,
    input  wire logic            instr_valid_i,
    // Register file
    output bfo_pkg::bfo_addr_t   rf_addr_o,
    input  wire bfo_pkg::bfo_data_t rf_rdata_i,
    output bfo_pkg::bfo_data_t   rf_wdata_o,
    output logic                 rf_we_o,
    // Pipeline control
    output logic                 flush_o,
    output logic                 nop_exec_o,
    output logic                 done_o,
    output logic                 status_we_o
);
    import bfo_pkg::*;

    logic [1:0]  dec_op;
    bfo_addr_t   dec_addr;
    bfo_bit_t    dec_bit;
    bfo_state_t  state_reg;
    bfo_state_t  state_next;
    bfo_addr_t   waddr_reg;
    bfo_addr_t   waddr_next;
    bfo_data_t   wdata_reg;
    bfo_data_t   wdata_next;
    logic        we_reg;
    logic        we_next;
    logic        done_reg;
    logic        done_next;
    logic        nop_reg;
    logic        nop_next;
    logic        sel_bit;

    // ======================================================================
    // Decode
    // ======================================================================
    bfo_decode i_bfo_decode (
        .word_i (instr_i),
        .op_o   (dec_op),
        .addr_o (dec_addr),
        .bit_o  (dec_bit)
    );

    function automatic bfo_data_t bfo_mod_bit(input bfo_data_t d, input bfo_bit_t b,
                                              input logic v);
        bfo_data_t r;
        r    = d;
        r[b] = v;
        return r;
    endfunction

    // The read address is combinational so the register file answers in the same cycle.
    assign rf_addr_o   = dec_addr;
    assign sel_bit     = rf_rdata_i[dec_bit];
    // No instruction handled here changes a status flag.
    assign status_we_o = 1'b0;
    // Flush is a combinational output, so the fetch stage drops its prefetch at once.
    assign flush_o     = (state_reg == BFO_ST_RUN) && instr_valid_i
                         && (dec_op == BFO_OP_TST) && !sel_bit;

    // ======================================================================
    // Execute
    // ======================================================================
    always_comb begin
        state_next = state_reg;
        waddr_next = waddr_reg;
        wdata_next = wdata_reg;
        we_next    = 1'b0;
        done_next  = 1'b0;
        nop_next   = 1'b0;
        case (state_reg)
            BFO_ST_RUN: begin
                if (instr_valid_i) begin
                    case (dec_op)
                        BFO_OP_CLR: begin
                            waddr_next = dec_addr;
                            wdata_next = bfo_mod_bit(rf_rdata_i, dec_bit, 1'b0);
                            we_next    = 1'b1;
                            done_next  = 1'b1;
                        end
                        BFO_OP_SET: begin
                            waddr_next = dec_addr;
                            wdata_next = bfo_mod_bit(rf_rdata_i, dec_bit, 1'b1);
                            we_next    = 1'b1;
                            done_next  = 1'b1;
                        end
                        BFO_OP_TST: begin
                            if (!sel_bit) begin
                                state_next = BFO_ST_FLUSH;
                            end else begin
                                done_next  = 1'b1;
                            end
                        end
                        default: begin
                            done_next = 1'b0;
                        end
                    endcase
                end
            end
            BFO_ST_FLUSH: begin
                // The discarded word is replaced by an idle cycle; its input is ignored.
                nop_next   = 1'b1;
                done_next  = 1'b1;
                state_next = BFO_ST_RUN;
            end
            default: begin
                state_next = BFO_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_reg <= BFO_ST_RUN;
            waddr_reg <= `BFO_RST_ADDR;
            wdata_reg <= `BFO_RST_DATA;
            we_reg    <= 1'b0;
            done_reg  <= 1'b0;
            nop_reg   <= 1'b0;
        end else begin
            state_reg <= state_next;
            waddr_reg <= waddr_next;
            wdata_reg <= wdata_next;
            we_reg    <= we_next;
            done_reg  <= done_next;
            nop_reg   <= nop_next;
        end
    end

    // Write-back is registered; the register file must write on the edge it sees rf_we_o.
    assign rf_wdata_o = wdata_reg;
    assign rf_we_o    = we_reg;
    assign done_o     = done_reg;
    assign nop_exec_o = nop_reg;

    // The write address is kept only for visibility, because the register file latches
    // its own write address from the read port one cycle before the write strobe.
    // A read of the same byte in the cycle straight after a modify still sees the old value.
    logic unused_waddr;
    assign unused_waddr = ^waddr_reg;
endmodule

// ==== bfo_exec_props.sv ====
// Checker for the bit-oriented execute stage.
`timescale 1ns/1ps
module bfo_exec_props (
    input wire logic        core_clk_i, input wire logic reset_i,
    input wire logic [13:0] instr_i,    input wire logic instr_valid_i,
    input wire logic [6:0]  rf_addr_o,  input wire logic [7:0] rf_rdata_i,
    input wire logic [7:0]  rf_wdata_o, input wire logic rf_we_o,
    input wire logic        flush_o,    input wire logic nop_exec_o,
    input wire logic        done_o,     input wire logic status_we_o
);
    // The word after a taken skip is discarded, so it is no request.
    logic       skip_reg;
    wire  [3:0] op = instr_i[13:10];
    wire  [7:0] m  = 8'h01 << instr_i[9:7];
    wire        tk = instr_valid_i && !skip_reg;
    wire        z  = !(|(rf_rdata_i & m));
    always_ff @(posedge core_clk_i) skip_reg <= reset_i ? 1'b0 : flush_o;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    property p_clr; tk && op == 4'h4 |=> rf_we_o && done_o &&
        rf_wdata_o == ($past(rf_rdata_i) & ~$past(m)); endproperty
    a_clr: assert property (p_clr) else $error("clear wrong");
    property p_set; tk && op == 4'h5 |=> rf_we_o && done_o &&
        rf_wdata_o == ($past(rf_rdata_i) | $past(m)); endproperty
    a_set: assert property (p_set) else $error("set wrong");
    property p_tst1; tk && op == 4'h6 && !z |-> !flush_o ##1 done_o && !rf_we_o; endproperty
    a_tst1: assert property (p_tst1) else $error("test one wrong");
    property p_tst0; tk && op == 4'h6 && z |-> flush_o ##1 !done_o && !rf_we_o
        ##1 nop_exec_o && done_o && !rf_we_o; endproperty
    a_tst0: assert property (p_tst0) else $error("skip wrong");
    property p_addr; rf_addr_o == instr_i[6:0]; endproperty
    a_addr: assert property (p_addr) else $error("address field wrong");
    property p_flush; flush_o |-> tk && op == 4'h6 && z; endproperty
    a_flush: assert property (p_flush) else $error("stray flush");
    property p_nop; nop_exec_o |-> $past(flush_o, 2); endproperty
    a_nop: assert property (p_nop) else $error("stray idle cycle");
    property p_we; rf_we_o |-> $past(tk && (op == 4'h4 || op == 4'h5)); endproperty
    a_we: assert property (p_we) else $error("stray write");
    property p_stat; !status_we_o; endproperty
    a_stat: assert property (p_stat) else $error("flag write");
endmodule
bind bfo_exec bfo_exec_props i_props (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .instr_i(instr_i), .instr_valid_i(instr_valid_i), .rf_addr_o(rf_addr_o),
    .rf_rdata_i(rf_rdata_i), .rf_wdata_o(rf_wdata_o), .rf_we_o(rf_we_o), .flush_o(flush_o),
    .nop_exec_o(nop_exec_o), .done_o(done_o), .status_we_o(status_we_o));

// ==== bfo_rf_model.sv ====
// Register file model with same-cycle read and delayed write.
`timescale 1ns/1ps
module bfo_rf_model (
    input  wire logic       clk_i,
    input  wire logic [6:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       we_i,
    output logic      [7:0] rdata_o
);
    // No forwarding: a read in the write cycle sees the old byte.
    logic [7:0] mem [128];
    logic [6:0] wa_reg;
    assign rdata_o = mem[addr_i];
    always @(posedge clk_i) begin
        if (we_i) mem[wa_reg] <= wdata_i;
        wa_reg <= addr_i;
    end
endmodule

// ==== bfo_exec_bench.sv ====
// Self-checking bench for the execute stage.
`timescale 1ns/1ps
module bfo_exec_bench;
    logic        core_clk_i = 0, reset_i = 1, instr_valid_i = 0;
    logic        rf_we_o, flush_o, nop_exec_o, done_o;
    logic [13:0] instr_i = '0;
    logic [6:0]  rf_addr_o, last_a, prev_f;
    logic [7:0]  rf_rdata_i, rf_wdata_o, shadow [128];
    logic [14:0] wq [$];
    int          n_mismatch = 0, cmp_count = 0, nq = 0, n_done = 0, exp_done = 0;
    always #25 core_clk_i = ~core_clk_i;
    bfo_exec i_bfo_exec (.core_clk_i(core_clk_i), .reset_i(reset_i), .instr_i(instr_i),
        .instr_valid_i(instr_valid_i), .rf_addr_o(rf_addr_o), .rf_rdata_i(rf_rdata_i),
        .rf_wdata_o(rf_wdata_o), .rf_we_o(rf_we_o), .flush_o(flush_o),
        .nop_exec_o(nop_exec_o), .done_o(done_o), .status_we_o());
    bfo_rf_model i_rf (.clk_i(core_clk_i), .addr_i(rf_addr_o), .wdata_i(rf_wdata_o),
        .we_i(rf_we_o), .rdata_o(rf_rdata_i));
    task automatic check(input logic [14:0] got, input logic [14:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic issue(input logic [3:0] op, input logic [6:0] f, input logic [2:0] b);
        logic [7:0] v;
        v = shadow[f];
        @(posedge core_clk_i) #1;
        instr_i = {op, b, f};
        instr_valid_i = 1;
        if (op inside {4'h4, 4'h5, 4'h6}) exp_done++;
        if (op == 4'h4 || op == 4'h5) begin
            v[b] = op[0];
            wq.push_back({f, v});
            shadow[f] = v;
        end else if (op == 4'h6 && !v[b]) begin
            nq++;
            @(posedge core_clk_i) #1;
            instr_i = {4'h5, b, f + 7'h1}; // A discarded word must write nothing.
        end
        prev_f = f;
    endtask
    always @(posedge core_clk_i) begin
        last_a <= rf_addr_o;
        if (!reset_i && rf_we_o) check({last_a, rf_wdata_o}, wq.size() ? wq.pop_front() : 'x);
        if (!reset_i && nop_exec_o) check(15'(nq > 0), 15'h1);
        if (!reset_i && nop_exec_o) nq--;
        if (!reset_i && done_o) n_done++;
    end
    initial begin
        #1000000;
        n_mismatch++;
        print_verdict;
    end
    initial begin
        logic [6:0] f;
        void'($urandom(16344));
        for (int i = 0; i < 128; i++) shadow[i] = 8'($urandom);
        shadow[3] = 8'hc7;
        shadow[5] = 8'h0a;
        i_rf.mem = shadow;
        repeat (4) @(posedge core_clk_i);
        #1 reset_i = 0;
        issue(4'h4, 7'd3, 3'd7);
        issue(4'h5, 7'd5, 3'd7);
        issue(4'h6, 7'd3, 3'd7);
        issue(4'h6, 7'd5, 3'd7);
        issue(4'h7, 7'd9, 3'd0);
        for (int i = 0; i < 300; i++) begin
            f = 7'($urandom);
            if (f == prev_f) f++;
            issue(4'h4 + 4'($urandom_range(2)), f, 3'($urandom));
        end
        @(posedge core_clk_i) #1 instr_valid_i = 0;
        repeat (4) @(posedge core_clk_i);
        check(15'(n_done), 15'(exp_done));
        check(15'(nq), 15'h0);
        check(15'(wq.size()), 15'h0);
        for (int i = 0; i < 128; i++) check({7'h0, i_rf.mem[i]}, {7'h0, shadow[i]});
        print_verdict;
    end
endmodule
